// ===== idm_pkg.sv
// Package for the internal data memory and special function register space
package idm_pkg;

    // Address space layout
    localparam logic [7:0] IDM_UPPER_BASE    = 8'h80;
    localparam logic [7:0] IDM_BITAREA_BASE  = 8'h20;
    localparam int         IDM_BITAREA_BYTES = 16;
    localparam int         IDM_BANK_REGS     = 8;

    // Register offsets
    localparam logic [7:0] OFS_PORT0      = 8'h80;
    localparam logic [7:0] OFS_SP         = 8'h81;
    localparam logic [7:0] OFS_PTR0_LO    = 8'h82;
    localparam logic [7:0] OFS_PTR0_HI    = 8'h83;
    localparam logic [7:0] OFS_PTR1_LO    = 8'h84;
    localparam logic [7:0] OFS_PTR1_HI    = 8'h85;
    localparam logic [7:0] OFS_PWR_CTRL   = 8'h87;
    localparam logic [7:0] OFS_TMR_CTRL   = 8'h88;
    localparam logic [7:0] OFS_TMR_MODE   = 8'h89;
    localparam logic [7:0] OFS_TMR0_LO    = 8'h8A;
    localparam logic [7:0] OFS_TMR1_LO    = 8'h8B;
    localparam logic [7:0] OFS_TMR0_HI    = 8'h8C;
    localparam logic [7:0] OFS_TMR1_HI    = 8'h8D;
    localparam logic [7:0] OFS_STRETCH    = 8'h8E;
    localparam logic [7:0] OFS_PORT1      = 8'h90;
    localparam logic [7:0] OFS_PTR_SEL    = 8'h92;
    localparam logic [7:0] OFS_SER0_CTRL  = 8'h98;
    localparam logic [7:0] OFS_SER0_BUF   = 8'h99;
    localparam logic [7:0] OFS_IRQ_EN2    = 8'h9A;
    localparam logic [7:0] OFS_SER1_CTRL  = 8'h9B;
    localparam logic [7:0] OFS_SER1_BUF   = 8'h9C;
    localparam logic [7:0] OFS_SER1_RLD_L = 8'h9D;
    localparam logic [7:0] OFS_PORT2      = 8'hA0;
    localparam logic [7:0] OFS_IRQ_EN0    = 8'hA8;
    localparam logic [7:0] OFS_IRQ_PRI0   = 8'hA9;
    localparam logic [7:0] OFS_SER0_RLD_L = 8'hAA;
    localparam logic [7:0] OFS_PORT3      = 8'hB0;
    localparam logic [7:0] OFS_IRQ_EN1    = 8'hB8;
    localparam logic [7:0] OFS_IRQ_PRI1   = 8'hB9;
    localparam logic [7:0] OFS_SER0_RLD_H = 8'hBA;
    localparam logic [7:0] OFS_SER1_RLD_H = 8'hBB;
    localparam logic [7:0] OFS_XDATA_PAGE = 8'hBF;
    localparam logic [7:0] OFS_IRQ_REQ    = 8'hC0;
    localparam logic [7:0] OFS_EXT_POL    = 8'hC8;
    localparam logic [7:0] OFS_PSW        = 8'hD0;
    localparam logic [7:0] OFS_BAUD_CTRL  = 8'hD8;
    localparam logic [7:0] OFS_RESULT     = 8'hE0;
    localparam logic [7:0] OFS_MULT       = 8'hF0;

    // Reset values
    localparam logic [7:0] RST_PORT     = 8'hFF;
    localparam logic [7:0] RST_SP       = 8'h07;
    localparam logic [7:0] RST_STRETCH  = 8'h01;
    localparam logic [7:0] RST_SER0_L   = 8'hD9;
    localparam logic [7:0] RST_SER_H    = 8'h03;
    localparam logic [7:0] RST_ZERO     = 8'h00;

    // Status word field positions
    localparam int PSW_CARRY  = 7;
    localparam int PSW_HALF   = 6;
    localparam int PSW_USER0  = 5;
    localparam int PSW_BANK_H = 4;
    localparam int PSW_BANK_L = 3;
    localparam int PSW_OVFL   = 2;
    localparam int PSW_USER1  = 1;
    localparam int PSW_PARITY = 0;

    // Number of implemented registers
    localparam int IDM_NREG = 38;

    // Access kind of a request
    typedef enum logic [1:0] {
        IDM_DIRECT,
        IDM_INDIRECT,
        IDM_BIT,
        IDM_WREG
    } idm_mode_type;

    // One request from the execution unit
    typedef struct packed {
        logic         rd;
        logic         wr;
        idm_mode_type mode;
        logic [7:0]   addr;
        logic [2:0]   bitpos;
        logic [7:0]   wdata;
    } idm_req_type;

    // Answer to the execution unit
    typedef struct packed {
        logic       valid;
        logic [7:0] rdata;
        logic       hit;
    } idm_rsp_type;

    // Flags written by arithmetic
    typedef struct packed {
        logic we;
        logic carry;
        logic half;
        logic ovfl;
    } idm_flags_type;

endpackage

// ===== idm_space.sv
// Internal data memory, upper indirect RAM and special function registers
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 256-byte internal space, one byte address
// - Registers from 0x80 only for direct and bit access
// - Indirect upper addresses reach separate 128-byte RAM
// - Lower 128 bytes shared by direct, indirect
// - Four eight-register banks at 8 times n
// - Status bits 4:3 select working bank
// - Bytes 0x20-0x2F bit addressable, rest bytes
// - Registers at low bits zero bit addressable
// - Unimplemented register writes change nothing
// - Reset loads listed register values
// - Result holder is implicit operand register
// - Multiply scratch used by multiply, divide, scratch
// - Status word flag layout carry to parity
// - Parity bit tracks result holder even parity
// - Stack pointer increments before push writes
module idm_space (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // Operand access
    input  wire idm_pkg::idm_req_type   req,
    input  wire logic              ind_via_ptr,
    input  wire logic              ind_ptr_sel,
    output var idm_pkg::idm_rsp_type rsp,
    // Arithmetic side ports
    input  wire idm_pkg::idm_flags_type flags_in,
    input  wire logic              mul_we,
    input  wire logic [7:0]        mul_result,
    input  wire logic [7:0]        mul_scratch,
    input  wire logic              stack_push,
    // Live register views
    output var logic [7:0]         result_q_out,
    output var logic [7:0]         status_q_out,
    output var logic [7:0]         stack_q_out
);
    import idm_pkg::*;

    typedef struct packed {
        logic [IDM_NREG-1:0][7:0] sfr;
        idm_rsp_type              rsp;
        logic [7:0]               res;
        logic [7:0]               program_status;
        logic [7:0]               sp;
    } idm_state_type;

    localparam logic [IDM_NREG*8-1:0] SFR_OFS = {
        OFS_PORT0, OFS_PTR0_LO, OFS_PTR0_HI, OFS_PTR1_LO, OFS_PTR1_HI, OFS_PWR_CTRL,
        OFS_TMR_CTRL, OFS_TMR_MODE, OFS_TMR0_LO, OFS_TMR1_LO, OFS_TMR0_HI, OFS_TMR1_HI,
        OFS_STRETCH, OFS_PORT1, OFS_PTR_SEL, OFS_SER0_CTRL, OFS_SER0_BUF, OFS_IRQ_EN2,
        OFS_SER1_CTRL, OFS_SER1_BUF, OFS_SER1_RLD_L, OFS_PORT2, OFS_IRQ_EN0,
        OFS_IRQ_PRI0, OFS_SER0_RLD_L, OFS_PORT3, OFS_IRQ_EN1, OFS_IRQ_PRI1,
        OFS_SER0_RLD_H, OFS_SER1_RLD_H, OFS_XDATA_PAGE, OFS_IRQ_REQ, OFS_EXT_POL,
        OFS_BAUD_CTRL, OFS_MULT, 8'h00, 8'h00, 8'h00
    };
    localparam logic [IDM_NREG*8-1:0] SFR_RST = {
        RST_PORT, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_STRETCH, RST_PORT, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO, RST_PORT, RST_ZERO,
        RST_ZERO, RST_SER0_L, RST_PORT, RST_ZERO, RST_ZERO,
        RST_SER_H, RST_SER_H, RST_ZERO, RST_ZERO, RST_ZERO,
        RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO
    };
    // The three trailing slots are unused; only 35 table entries are valid
    localparam int SFR_USED = 35;
    localparam int MULT_IDX = 3;

    // Lower RAM and separate upper RAM are plain arrays outside the state struct
    logic [7:0] lower_ram [0:127];
    logic [7:0] upper_ram [0:127];

    idm_state_type st_q;
    idm_state_type st_d;

    logic [7:0]  eff_addr;
    logic [7:0]  ptr_val;
    logic [7:0]  ram_rd;
    logic [7:0]  byte_rd;
    logic [7:0]  byte_wr;
    logic [7:0]  bit_byte;
    logic        is_upper;
    logic        upper_ind;
    logic        low_we;
    logic        up_we;
    logic        sfr_hit;
    logic [5:0]  sfr_idx;
    logic        bit_ok;

    function automatic logic [7:0] sfr_ofs(input int i);
        sfr_ofs = SFR_OFS[(IDM_NREG-1-i)*8 +: 8];
    endfunction

    // Pointer register of the active bank
    always_comb begin
        ptr_val = lower_ram[{2'b00, st_q.program_status[PSW_BANK_H:PSW_BANK_L], 2'b00, ind_ptr_sel}];
    end

    // Address formation
    always_comb begin
        eff_addr = req.addr;
        unique case (req.mode)
            IDM_WREG:     eff_addr = {3'b000, st_q.program_status[PSW_BANK_H:PSW_BANK_L], req.addr[2:0]};
            IDM_INDIRECT: eff_addr = ind_via_ptr ? ptr_val : req.addr;
            // Bit numbers below 0x80 map onto bytes 0x20-0x2F
            IDM_BIT:      eff_addr = req.addr[7] ? {req.addr[7:3], 3'b000}
                                     : (IDM_BITAREA_BASE | {4'h0, req.addr[6:3]});
            IDM_DIRECT:   eff_addr = req.addr;
        endcase
        is_upper  = eff_addr[7];
        upper_ind = is_upper && (req.mode == IDM_INDIRECT);
    end

    // Register decode
    always_comb begin
        sfr_hit = 1'b0;
        sfr_idx = 6'd0;
        for (int i = 0; i < SFR_USED; i++) begin
            if (eff_addr == sfr_ofs(i)) begin
                sfr_hit = 1'b1;
                // Table entry i sits at packed slot IDM_NREG-1-i, like the reset image
                sfr_idx = 6'(IDM_NREG - 1 - i);
            end
        end
    end

    always_comb begin
        ram_rd = upper_ind ? upper_ram[eff_addr[6:0]] : lower_ram[eff_addr[6:0]];
        if (!is_upper || upper_ind) begin
            byte_rd = ram_rd;
        end else if (eff_addr == OFS_RESULT) begin
            byte_rd = st_q.res;
        end else if (eff_addr == OFS_PSW) begin
            byte_rd = st_q.program_status;
        end else if (eff_addr == OFS_SP) begin
            byte_rd = st_q.sp;
        end else if (sfr_hit) begin
            byte_rd = st_q.sfr[sfr_idx];
        end else begin
            byte_rd = RST_ZERO;
        end
        bit_byte = byte_rd;
        bit_byte[req.bitpos] = req.wdata[0];
        byte_wr  = (req.mode == IDM_BIT) ? bit_byte : req.wdata;
        bit_ok   = (req.mode != IDM_BIT) || !is_upper || (eff_addr[2:0] == 3'b000);
        low_we   = req.wr && bit_ok && !is_upper;
        up_we    = req.wr && upper_ind;
    end

    // Next state
    always_comb begin
        st_d = st_q;
        st_d.rsp.valid = req.rd;
        st_d.rsp.hit   = !is_upper || upper_ind || sfr_hit
                         || eff_addr == OFS_RESULT || eff_addr == OFS_PSW || eff_addr == OFS_SP;
        st_d.rsp.rdata = (req.mode == IDM_BIT) ? {7'd0, byte_rd[req.bitpos]} : byte_rd;
        if (flags_in.we) begin
            st_d.program_status[PSW_CARRY] = flags_in.carry;
            st_d.program_status[PSW_HALF]  = flags_in.half;
            st_d.program_status[PSW_OVFL]  = flags_in.ovfl;
        end
        if (stack_push) begin
            st_d.sp = st_q.sp + 8'h01;
        end
        if (mul_we) begin
            st_d.res = mul_result;
            st_d.sfr[MULT_IDX] = mul_scratch;
        end
        // Software writes take precedence over the arithmetic side ports
        if (req.wr && bit_ok && is_upper && !upper_ind) begin
            if (eff_addr == OFS_RESULT) begin
                st_d.res = byte_wr;
            end else if (eff_addr == OFS_PSW) begin
                st_d.program_status = byte_wr;
            end else if (eff_addr == OFS_SP) begin
                st_d.sp = byte_wr;
            end else if (sfr_hit) begin
                st_d.sfr[sfr_idx] = byte_wr;
            end
        end
        // Parity is recomputed from the next accumulator so it never lags
        st_d.program_status[PSW_PARITY] = ^st_d.res;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_q.sfr <= SFR_RST;
            st_q.rsp <= '0;
            st_q.res <= RST_ZERO;
            st_q.program_status <= RST_ZERO;
            st_q.sp  <= RST_SP;
        end else begin
            st_q <= st_d;
        end
    end

    // RAM has no reset: its content after power-up is undefined
    always_ff @(posedge clk_sys) begin
        if (low_we) begin
            lower_ram[eff_addr[6:0]] <= byte_wr;
        end
        if (up_we) begin
            upper_ram[eff_addr[6:0]] <= byte_wr;
        end
    end

    assign rsp          = st_q.rsp;
    assign result_q_out = st_q.res;
    assign status_q_out = st_q.program_status;
    assign stack_q_out  = st_q.sp;

    // Checks
    parity_even_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        ^{st_q.res, st_q.program_status[PSW_PARITY]} == 1'b0) else $error("parity bit wrong");
    push_incr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        stack_push && !req.wr |=> st_q.sp == $past(st_q.sp) + 8'h01)
        else $error("stack pointer not incremented");
    direct_upper_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.wr && req.mode == IDM_DIRECT |-> !up_we) else $error("direct hit upper ram");
    ind_upper_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        upper_ind && req.wr && !stack_push && !flags_in.we && !mul_we
        |=> st_q.sfr == $past(st_q.sfr) && st_q.sp == $past(st_q.sp))
        else $error("indirect reached register");
    unimpl_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.wr && req.mode == IDM_DIRECT && is_upper && !sfr_hit && eff_addr != OFS_RESULT
        && eff_addr != OFS_PSW && eff_addr != OFS_SP && !stack_push && !flags_in.we && !mul_we
        |=> $stable({st_q.sfr, st_q.res, st_q.program_status, st_q.sp}))
        else $error("unimplemented write changed state");
    bank_addr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.mode == IDM_WREG |-> eff_addr == {3'b000, st_q.program_status[4:3], req.addr[2:0]})
        else $error("bank address wrong");
    bit_area_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.mode == IDM_BIT && !req.addr[7] |-> eff_addr[7:4] == 4'h2)
        else $error("bit outside bit area");
    bit_sfr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.mode == IDM_BIT && is_upper |-> eff_addr[2:0] == 3'b000)
        else $error("bit access to byte register");
    read_valid_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        req.rd |=> st_q.rsp.valid) else $error("read not answered");
    flag_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        flags_in.we && !req.wr |=> st_q.program_status[PSW_CARRY] == $past(flags_in.carry))
        else $error("carry not updated");

    push_cov: cover property (@(posedge clk_sys) disable iff (sys_rst) stack_push);
    ind_up_cov: cover property (@(posedge clk_sys) disable iff (sys_rst) up_we);
    bank3_cov: cover property (@(posedge clk_sys) disable iff (sys_rst)
        req.mode == IDM_WREG && st_q.program_status[4:3] == 2'b11);
    bitset_cov: cover property (@(posedge clk_sys) disable iff (sys_rst)
        req.wr && req.mode == IDM_BIT && is_upper);

endmodule
`default_nettype wire

// ===== idm_exec_model.sv
// Execution unit model that issues operand cycles into the data space
`timescale 1ns/1ps
`default_nettype none
module idm_exec_model (
    // Clock
    input  wire logic                   clk_sys,
    // Operand access
    output var  idm_pkg::idm_req_type   req,
    output var  logic                   ind_via_ptr,
    output var  logic                   ind_ptr_sel,
    // Arithmetic side
    output var  idm_pkg::idm_flags_type flags_in,
    output var  logic                   mul_we,
    output var  logic [7:0]             mul_result,
    output var  logic [7:0]             mul_scratch,
    output var  logic                   stack_push
);
    import idm_pkg::*;

    initial begin
        req = '0;
        ind_via_ptr = 1'b0;
        ind_ptr_sel = 1'b0;
        flags_in = '0;
        {mul_we, mul_result, mul_scratch, stack_push} = '0;
    end

    // One operand cycle; side ports idle so a bus write never races them
    task automatic op(input idm_req_type r, input logic vp, input logic ps);
        req = r;
        ind_via_ptr = vp;
        ind_ptr_sel = ps;
        {flags_in, mul_we, stack_push} = '0;
        @(posedge clk_sys);
        #1;
    endtask

    // Arithmetic or stack cycle with the operand bus idle
    task automatic side(input idm_flags_type f, input logic mw, input logic [15:0] v,
                        input logic push);
        req = '0;
        flags_in = f;
        mul_we = mw;
        {mul_result, mul_scratch} = v;
        stack_push = push;
        @(posedge clk_sys);
        #1;
    endtask
endmodule
`default_nettype wire

// ===== internal_data_memory_sfr_space_tb_top.sv
// Self-checking bench for the internal data space and its registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module internal_data_memory_sfr_space_tb_top;
    import idm_pkg::*;
    logic           clk_sys = 1'b0;
    logic           sys_rst = 1'b1;
    idm_req_type    req;
    logic           ind_via_ptr;
    logic           ind_ptr_sel;
    idm_rsp_type    rsp;
    idm_flags_type  flags_in;
    logic           mul_we;
    logic [7:0]     mul_result;
    logic [7:0]     mul_scratch;
    logic           stack_push;
    logic [7:0]     result_v;
    logic [7:0]     status_v;
    logic [7:0]     stack_v;
    int             failures = 0;
    int             samples_checked = 0;
    int             seed = 80636;
    logic [7:0]     r;
    logic [8:0]     exp_v;
    logic [8:0]     expq[$];
    logic [15:0]    rst_tab[12] = '{16'h80FF, 16'h8107, 16'h8E01, 16'h90FF, 16'hAAD9,
        16'hBA03, 16'hBB03, 16'h9D00, 16'hD000, 16'hE000, 16'hF000, 16'hB0FF};

    always #2.5 clk_sys = ~clk_sys;

    idm_exec_model i_exec (.clk_sys(clk_sys), .req(req), .ind_via_ptr(ind_via_ptr),
        .ind_ptr_sel(ind_ptr_sel), .flags_in(flags_in), .mul_we(mul_we),
        .mul_result(mul_result), .mul_scratch(mul_scratch), .stack_push(stack_push));

    idm_space i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req),
        .ind_via_ptr(ind_via_ptr), .ind_ptr_sel(ind_ptr_sel), .rsp(rsp),
        .flags_in(flags_in), .mul_we(mul_we), .mul_result(mul_result),
        .mul_scratch(mul_scratch), .stack_push(stack_push), .result_q_out(result_v),
        .status_q_out(status_v), .stack_q_out(stack_v));

    task automatic wr(input idm_mode_type m, input logic [7:0] a, input logic [7:0] d,
                      input logic [2:0] b = 3'h0, input logic vp = 1'b0,
                      input logic ps = 1'b0);
        i_exec.op('{1'b0, 1'b1, m, a, b, d}, vp, ps);
    endtask

    // Expected answer is {hit, data}, queued before the read is launched
    task automatic rd(input idm_mode_type m, input logic [7:0] a, input logic [8:0] e);
        expq.push_back(e);
        i_exec.op('{1'b1, 1'b0, m, a, 3'h0, 8'h00}, 1'b0, 1'b0);
    endtask

    task automatic complete_run();
        $display("checks=%0d failures=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Answer stands one cycle, so it is taken mid-cycle where it has settled
    always @(negedge clk_sys) begin
        if (rsp.valid === 1'b1) begin
            if (expq.size() == 0) begin
                failures++;
                $display("mismatch t=%0t got=%0h exp=none", $time, rsp.rdata);
            end else begin
                exp_v = expq.pop_front();
                `CHK({rsp.hit, rsp.rdata}, exp_v)
            end
        end
    end

    // Whole run is under a hundred cycles; five times that is the limit
    initial begin
        #(5 * 500);
        failures++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        #1;
        sys_rst = 1'b0;
        foreach (rst_tab[i]) rd(IDM_DIRECT, rst_tab[i][15:8], {1'b1, rst_tab[i][7:0]});
        i_exec.side('0, 1'b0, 16'h0000, 1'b1);
        `CHK(stack_v, 8'h08)
        wr(IDM_BIT, OFS_SP, 8'h01, 3'h2);
        rd(IDM_DIRECT, OFS_SP, {1'b1, 8'h08});
        r = 8'($random(seed));
        wr(IDM_DIRECT, 8'h86, r);
        rd(IDM_DIRECT, 8'h86, 9'h000);
        rd(IDM_DIRECT, OFS_PWR_CTRL, {1'b1, 8'h00});
        wr(IDM_INDIRECT, OFS_PORT1, ~r);
        wr(IDM_DIRECT, OFS_PORT1, r);
        rd(IDM_INDIRECT, OFS_PORT1, {1'b1, ~r});
        rd(IDM_DIRECT, OFS_PORT1, {1'b1, r});
        wr(IDM_DIRECT, 8'h7F, r);
        wr(IDM_INDIRECT, 8'h30, ~r);
        wr(IDM_INDIRECT, 8'hFF, r ^ 8'h5A);
        rd(IDM_INDIRECT, 8'h7F, {1'b1, r});
        rd(IDM_DIRECT, 8'h30, {1'b1, ~r});
        rd(IDM_INDIRECT, 8'hFF, {1'b1, r ^ 8'h5A});
        for (int b = 0; b < 4; b++) begin
            r = 8'($random(seed));
            wr(IDM_DIRECT, OFS_PSW, 8'(b << 3));
            wr(IDM_DIRECT, 8'(8 * b + b % 2), 8'(8'h40 + b));
            wr(IDM_INDIRECT, 8'h00, r, 3'h0, 1'b1, b[0]);
            rd(IDM_DIRECT, 8'(8'h40 + b), {1'b1, r});
        end
        rd(IDM_DIRECT, OFS_PSW, {1'b1, 8'h18});
        wr(IDM_DIRECT, 8'h21, 8'h00);
        wr(IDM_BIT, 8'h0B, 8'h01, 3'h3);
        rd(IDM_DIRECT, 8'h21, {1'b1, 8'h08});
        wr(IDM_BIT, OFS_TMR_CTRL, 8'h01, 3'h5);
        rd(IDM_DIRECT, OFS_TMR_CTRL, {1'b1, 8'h20});
        r = 8'($random(seed));
        i_exec.side('0, 1'b1, {r, ~r}, 1'b0);
        rd(IDM_DIRECT, OFS_RESULT, {1'b1, r});
        rd(IDM_DIRECT, OFS_MULT, {1'b1, ~r});
        i_exec.side('{1'b1, 1'b1, 1'b0, 1'b1}, 1'b0, 16'h0000, 1'b0);
        rd(IDM_DIRECT, OFS_PSW, {1'b1, 8'h9C | {7'h00, ^r}});
        for (int i = 0; i < 4; i++) begin
            r = 8'($random(seed));
            wr(IDM_DIRECT, OFS_RESULT, r);
            rd(IDM_DIRECT, OFS_PSW, {1'b1, 8'h9C | {7'h00, ^r}});
            `CHK(status_v[0], ^result_v)
        end
        i_exec.side('0, 1'b0, 16'h0000, 1'b0);
        repeat (3) @(posedge clk_sys);
        `CHK(expq.size(), 0)
        complete_run();
    end
endmodule
`default_nettype wire
